// [rtl/wiper_cmd_pkg.sv]
// shared constants and types for the wiper shortcut command engine
// assumes a byte-level bus front end delivers decoded command strobes
package wiper_cmd_pkg;
    localparam int          CLK_HZ          = 25_000_000;
    localparam int          STORE_MS        = 25;
    localparam int          STORE_CYCLES    = (CLK_HZ / 1000) * STORE_MS;
    localparam int          CH_WIDTH        = 9;
    localparam int          CH2_WIDTH       = 7;
    localparam int          CH_BITS         = 2;
    localparam logic [1:0]  CH_LAST         = 2'h2;
    localparam logic [6:0]  DEV_ADDR_BASE   = 7'h2c;
    localparam logic [6:0]  NVMEM_ADDR_BASE = 7'h50;

    typedef enum logic [3:0] {
        CMD_NOP       = 4'b0000,
        CMD_RESTORE   = 4'b0001,
        CMD_STORE     = 4'b0010,
        CMD_DEC_6DB   = 4'b0011,
        CMD_DEC_6DB_A = 4'b0100,
        CMD_DEC_STEP  = 4'b0101,
        CMD_DEC_STP_A = 4'b0110,
        CMD_RESET     = 4'b0111,
        CMD_INC_6DB   = 4'b1000,
        CMD_INC_6DB_A = 4'b1001,
        CMD_INC_STEP  = 4'b1010,
        CMD_INC_STP_A = 4'b1011
    } cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_LOAD    = 2'b01,
        ST_STORE   = 2'b10,
        ST_MEMREAD = 2'b11
    } state_t;

    typedef struct packed {
        logic                 valid;
        logic [3:0]           code;
        logic [CH_BITS-1:0]   channel;
    } cmd_req_t;

    typedef struct packed {
        logic [CH_WIDTH-1:0]  wiper0;
        logic [CH_WIDTH-1:0]  wiper1;
        logic [CH2_WIDTH-1:0] wiper2;
    } wipers_t;
endpackage

// [rtl/wiper_shortcut_command_engine.sv]
// wiper registers of a three-channel potentiometer and their shortcut commands
// assumes the serial front end presents commands and direct writes as one-cycle strobes
// and that the nonvolatile array is a simple word memory modelled inside this block
`timescale 1ns/1ps
`default_nettype none
module wiper_shortcut_command_engine #(
    parameter int STORE_CYCLES = wiper_cmd_pkg::STORE_CYCLES
) (
    input  wire logic                      i_core_clk,
    input  wire logic                      i_rst,
    input  wire wiper_cmd_pkg::cmd_req_t   i_cmd,
    input  wire logic                      i_wr_valid,
    input  wire logic [1:0]                i_wr_channel,
    input  wire logic [8:0]                i_wr_data,
    input  wire logic                      i_hw_reset_n,
    input  wire logic                      i_write_protect_n,
    input  wire logic                      i_target_addr_pin_lo,
    input  wire logic                      i_target_addr_pin_hi,
    input  wire logic                      i_nvmem_addr_pin_lo,
    input  wire logic                      i_nvmem_addr_pin_hi,
    output var  wiper_cmd_pkg::wipers_t    o_wiper,
    output logic                           o_busy,
    output logic                           o_mem_read_state,
    output logic [6:0]                     o_target_addr,
    output logic [6:0]                     o_nvmem_addr
);
    localparam int W0 = wiper_cmd_pkg::CH_WIDTH;
    localparam int W2 = wiper_cmd_pkg::CH2_WIDTH;

    // pin synchronisers
    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;
    always_ff @(posedge i_core_clk) begin
        pin_meta_reg <= {i_hw_reset_n, i_write_protect_n, i_target_addr_pin_hi,
                         i_target_addr_pin_lo, i_nvmem_addr_pin_hi};
        pin_sync_reg <= pin_meta_reg;
    end
    logic nv_lo_meta_reg;
    logic nv_lo_sync_reg;
    always_ff @(posedge i_core_clk) begin
        nv_lo_meta_reg <= i_nvmem_addr_pin_lo;
        nv_lo_sync_reg <= nv_lo_meta_reg;
    end
    logic hw_reset_n_s;
    logic wp_n_s;
    assign hw_reset_n_s = pin_sync_reg[4];
    assign wp_n_s       = pin_sync_reg[3];

    // bus addresses formed from strap pins
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_target_addr <= 7'h00;
            o_nvmem_addr  <= 7'h00;
        end else begin
            o_target_addr <= wiper_cmd_pkg::DEV_ADDR_BASE | {5'h00, pin_sync_reg[2:1]};
            o_nvmem_addr  <= wiper_cmd_pkg::NVMEM_ADDR_BASE
                             | {5'h00, pin_sync_reg[0], nv_lo_sync_reg};
        end
    end

    // per-channel width helpers
    function automatic logic [8:0] full_scale(input logic [1:0] ch);
        full_scale = (ch == 2'h2) ? 9'h07f : 9'h1ff;
    endfunction
    function automatic logic [8:0] step_up(input logic [8:0] v, input logic [1:0] ch);
        step_up = (v == full_scale(ch)) ? v : v + 9'h001;
    endfunction
    function automatic logic [8:0] step_dn(input logic [8:0] v);
        step_dn = (v == 9'h000) ? v : v - 9'h001;
    endfunction
    function automatic logic [8:0] shl(input logic [8:0] v, input logic [1:0] ch);
        logic [8:0] fs;
        fs = full_scale(ch);
        if (v == 9'h000)
            shl = 9'h001;
        else if (v > (fs >> 1))
            shl = fs;
        else
            shl = {v[7:0], 1'b0};
    endfunction
    function automatic logic [8:0] shr(input logic [8:0] v);
        shr = {1'b0, v[8:1]};
    endfunction

    // nonvolatile copies and volatile wipers
    logic [8:0] nv_mem [3];
    logic [8:0] wiper_reg [3];
    wiper_cmd_pkg::state_t state_reg;
    localparam int CNT_W = $clog2(STORE_CYCLES + 1);
    logic [CNT_W-1:0] store_cnt_reg;
    logic [1:0] store_ch_reg;
    logic hw_reset_d_reg;
    // comes up clear so only the first reset after power-up erases the array
    logic power_on_reg = 1'b0;

    logic [3:0] code;
    logic       all_ch;
    logic       accept;
    assign code   = i_cmd.code;
    assign accept = i_cmd.valid && (state_reg != wiper_cmd_pkg::ST_STORE)
                    && (state_reg != wiper_cmd_pkg::ST_LOAD);
    assign all_ch = (code == wiper_cmd_pkg::CMD_DEC_6DB_A) || (code == wiper_cmd_pkg::CMD_DEC_STP_A)
                    || (code == wiper_cmd_pkg::CMD_INC_6DB_A) || (code == wiper_cmd_pkg::CMD_INC_STP_A);

    logic hw_reset_fall;
    assign hw_reset_fall = hw_reset_d_reg && !hw_reset_n_s;
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            hw_reset_d_reg <= 1'b1;
        else
            hw_reset_d_reg <= hw_reset_n_s;
    end

    // nonvolatile array; erased value is zero, writes only while unprotected
    always_ff @(posedge i_core_clk) begin
        if (i_rst && !power_on_reg) begin
            for (int i = 0; i < 3; i++)
                nv_mem[i] <= 9'h000;
        end else if (state_reg == wiper_cmd_pkg::ST_STORE && store_cnt_reg == '0 && wp_n_s) begin
            nv_mem[store_ch_reg] <= wiper_reg[store_ch_reg];
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (i_rst)
            power_on_reg <= 1'b1;
    end

    // command sequencer
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_reg     <= wiper_cmd_pkg::ST_LOAD;
            store_cnt_reg <= '0;
            store_ch_reg  <= 2'h0;
        end else if (hw_reset_fall) begin
            state_reg <= wiper_cmd_pkg::ST_LOAD;
        end else begin
            case (state_reg)
                wiper_cmd_pkg::ST_LOAD: begin
                    state_reg <= wiper_cmd_pkg::ST_IDLE;
                end
                wiper_cmd_pkg::ST_STORE: begin
                    if (store_cnt_reg == '0)
                        state_reg <= wiper_cmd_pkg::ST_IDLE;
                    else
                        store_cnt_reg <= store_cnt_reg - CNT_W'(1);
                end
                default: begin
                    if (accept) begin
                        if (code == wiper_cmd_pkg::CMD_RESTORE) begin
                            state_reg <= wiper_cmd_pkg::ST_MEMREAD;
                        end else if (code == wiper_cmd_pkg::CMD_RESET) begin
                            state_reg <= wiper_cmd_pkg::ST_LOAD;
                        end else if (code == wiper_cmd_pkg::CMD_STORE && i_cmd.channel <= wiper_cmd_pkg::CH_LAST) begin
                            state_reg     <= wiper_cmd_pkg::ST_STORE;
                            store_ch_reg  <= i_cmd.channel;
                            store_cnt_reg <= CNT_W'(STORE_CYCLES - 1);
                        end else if (code == wiper_cmd_pkg::CMD_NOP) begin
                            state_reg <= wiper_cmd_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // wiper register updates
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            for (int i = 0; i < 3; i++)
                wiper_reg[i] <= 9'h000;
        end else if (state_reg == wiper_cmd_pkg::ST_LOAD) begin
            for (int i = 0; i < 3; i++)
                wiper_reg[i] <= nv_mem[i];
        end else if (accept && code == wiper_cmd_pkg::CMD_RESTORE
                     && i_cmd.channel <= wiper_cmd_pkg::CH_LAST) begin
            wiper_reg[i_cmd.channel] <= nv_mem[i_cmd.channel];
        end else if (accept) begin
            for (int i = 0; i < 3; i++) begin
                if (all_ch || i_cmd.channel == 2'(i)) begin
                    case (code)
                        wiper_cmd_pkg::CMD_INC_STEP, wiper_cmd_pkg::CMD_INC_STP_A:
                            wiper_reg[i] <= step_up(wiper_reg[i], 2'(i));
                        wiper_cmd_pkg::CMD_DEC_STEP, wiper_cmd_pkg::CMD_DEC_STP_A:
                            wiper_reg[i] <= step_dn(wiper_reg[i]);
                        wiper_cmd_pkg::CMD_INC_6DB, wiper_cmd_pkg::CMD_INC_6DB_A:
                            wiper_reg[i] <= shl(wiper_reg[i], 2'(i));
                        wiper_cmd_pkg::CMD_DEC_6DB, wiper_cmd_pkg::CMD_DEC_6DB_A:
                            wiper_reg[i] <= shr(wiper_reg[i]);
                        default: ;
                    endcase
                end
            end
        end else if (i_wr_valid && !o_busy && i_wr_channel <= wiper_cmd_pkg::CH_LAST) begin
            wiper_reg[i_wr_channel] <= i_wr_data & full_scale(i_wr_channel);
        end
    end

    // wiper outputs follow the volatile registers directly
    assign o_wiper.wiper0 = wiper_reg[0][W0-1:0];
    assign o_wiper.wiper1 = wiper_reg[1][W0-1:0];
    assign o_wiper.wiper2 = wiper_reg[2][W2-1:0];
    assign o_busy = (state_reg == wiper_cmd_pkg::ST_STORE)
                    || (state_reg == wiper_cmd_pkg::ST_LOAD);
    assign o_mem_read_state = (state_reg == wiper_cmd_pkg::ST_MEMREAD);

    chk_store_busy_span: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(state_reg == wiper_cmd_pkg::ST_STORE) |-> o_busy [*8]) else $error("store ended early");
    chk_shl_zero_one: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (accept && code == wiper_cmd_pkg::CMD_INC_6DB && i_cmd.channel == 2'h0 && wiper_reg[0] == 9'h000)
        |=> wiper_reg[0] == 9'h001) else $error("left shift of zero wrong");
    chk_shl_saturate: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (accept && code == wiper_cmd_pkg::CMD_INC_6DB_A && wiper_reg[1] >= 9'h100)
        |=> wiper_reg[1] == 9'h1ff) else $error("left shift not saturated");
    chk_shr_halves: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (accept && code == wiper_cmd_pkg::CMD_DEC_6DB_A)
        |=> wiper_reg[2] == {1'b0, $past(wiper_reg[2][8:1])}) else $error("right shift wrong");
    chk_inc_no_wrap: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (accept && code == wiper_cmd_pkg::CMD_INC_STP_A && wiper_reg[2] == 9'h07f)
        |=> wiper_reg[2] == 9'h07f) else $error("step wrapped");
    chk_dec_step: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (accept && code == wiper_cmd_pkg::CMD_DEC_STEP && i_cmd.channel == 2'h1 && wiper_reg[1] != 9'h000)
        |=> wiper_reg[1] == $past(wiper_reg[1]) - 9'h001) else $error("step down wrong");
    chk_restore_memread: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (accept && code == wiper_cmd_pkg::CMD_RESTORE) |=> o_mem_read_state) else $error("no memread state");
    chk_reset_reload: assert property (@(posedge i_core_clk) disable iff (i_rst)
        hw_reset_fall |=> ##1 wiper_reg[0] == nv_mem[0]) else $error("reset did not reload");
    chk_wp_blocks: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !wp_n_s |=> $stable(nv_mem[0])) else $error("write while protected");
endmodule
`default_nettype wire

// [verification/bus_master_model.sv]
// bus master model that sends shortcut commands and direct wiper writes
// assumes the engine samples its strobes on the rising edge of i_core_clk
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    input  wire logic                    i_core_clk,
    input  wire logic                    i_busy,
    output var  wiper_cmd_pkg::cmd_req_t o_cmd,
    output logic                         o_wr_valid,
    output logic [1:0]                   o_wr_channel,
    output logic [8:0]                   o_wr_data
);
    initial begin
        o_cmd = '0;
        o_wr_valid = 1'b0;
        o_wr_channel = 2'h0;
        o_wr_data = 9'h000;
    end

    // one-cycle strobe carrying the 4-bit command field
    task automatic issue(input logic [3:0] code, input logic [1:0] ch);
        @(posedge i_core_clk);
        o_cmd <= '{valid: 1'b1, code: code, channel: ch};
        @(posedge i_core_clk);
        o_cmd <= '{valid: 1'b0, code: 4'h0, channel: 2'h0};
    endtask

    task automatic write(input logic [1:0] ch, input logic [8:0] data);
        @(posedge i_core_clk);
        o_wr_valid <= 1'b1;
        o_wr_channel <= ch;
        o_wr_data <= data;
        @(posedge i_core_clk);
        o_wr_valid <= 1'b0;
        o_wr_data <= ~data;
    endtask

    // keep addressing until busy drops or 1000 polls pass, busy standing for no acknowledge
    task automatic poll();
        int n;
        n = 0;
        repeat (2) @(posedge i_core_clk);
        #1;
        while (i_busy !== 1'b0 && n < 1000) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
    endtask
endmodule
`default_nettype wire

// [verification/tb_wiper_shortcut_command_engine.sv]
// self-checking bench for the wiper shortcut command engine
// assumes the bus master model and the engine share one clock
`timescale 1ns/1ps
`default_nettype none
module tb_wiper_shortcut_command_engine;
    localparam int STORE = 16;
    logic                    i_core_clk;
    logic                    i_rst;
    logic                    i_hw_reset_n;
    logic                    i_write_protect_n;
    logic [3:0]              pins;
    wiper_cmd_pkg::cmd_req_t cmd;
    logic                    wr_valid;
    logic [1:0]              wr_channel;
    logic [8:0]              wr_data;
    wiper_cmd_pkg::wipers_t  o_wiper;
    logic                    o_busy;
    logic                    o_mem_read_state;
    logic [6:0]              o_target_addr;
    logic [6:0]              o_nvmem_addr;
    int                      fails = 0;
    int                      tests_run = 0;
    int                      cycles = 0;

    wiper_shortcut_command_engine #(.STORE_CYCLES(STORE)) wiper_shortcut_command_engine_inst (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_cmd(cmd), .i_wr_valid(wr_valid),
        .i_wr_channel(wr_channel), .i_wr_data(wr_data), .i_hw_reset_n(i_hw_reset_n),
        .i_write_protect_n(i_write_protect_n), .i_target_addr_pin_lo(pins[0]),
        .i_target_addr_pin_hi(pins[1]), .i_nvmem_addr_pin_lo(pins[2]),
        .i_nvmem_addr_pin_hi(pins[3]), .o_wiper(o_wiper), .o_busy(o_busy),
        .o_mem_read_state(o_mem_read_state), .o_target_addr(o_target_addr),
        .o_nvmem_addr(o_nvmem_addr));

    bus_master_model bus_master_model_inst (
        .i_core_clk(i_core_clk), .i_busy(o_busy), .o_cmd(cmd), .o_wr_valid(wr_valid),
        .o_wr_channel(wr_channel), .o_wr_data(wr_data));

    initial begin
        i_core_clk = 1'b0;
        forever #20 i_core_clk = ~i_core_clk;
    end

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge i_core_clk);
        #1;
    endtask

    task automatic do_cmd(input logic [3:0] c, input logic [1:0] ch);
        bus_master_model_inst.issue(c, ch);
        tick(1);
    endtask

    task automatic wr(input logic [1:0] ch, input logic [8:0] d);
        bus_master_model_inst.write(ch, d);
        tick(1);
    endtask

    task automatic chk3(input logic [8:0] e0, input logic [8:0] e1, input logic [6:0] e2);
        check(o_wiper.wiper0, e0);
        check(o_wiper.wiper1, e1);
        check({2'h0, o_wiper.wiper2}, {2'h0, e2});
    endtask

    task automatic t_addr_pins();
        for (int p = 0; p < 4; p++) begin
            @(posedge i_core_clk);
            pins <= {p[1:0], p[1:0]};
            tick(5);
            check({2'h0, o_target_addr}, {2'h0, wiper_cmd_pkg::DEV_ADDR_BASE | 7'(p)});
            check({2'h0, o_nvmem_addr}, {2'h0, wiper_cmd_pkg::NVMEM_ADDR_BASE | 7'(p)});
        end
    endtask

    task automatic t_steps();
        wr(2'h0, 9'h1ff);
        check(o_wiper.wiper0, 9'h1ff);
        do_cmd(wiper_cmd_pkg::CMD_INC_STEP, 2'h0);
        check(o_wiper.wiper0, 9'h1ff);
        do_cmd(wiper_cmd_pkg::CMD_DEC_STEP, 2'h0);
        check(o_wiper.wiper0, 9'h1fe);
        wr(2'h2, 9'h07f);
        do_cmd(wiper_cmd_pkg::CMD_INC_STP_A, 2'h0);
        chk3(9'h1ff, 9'h001, 7'h7f);
        wr(2'h1, 9'h000);
        do_cmd(wiper_cmd_pkg::CMD_DEC_STP_A, 2'h0);
        chk3(9'h1fe, 9'h000, 7'h7e);
        wr(2'h1, 9'h100);
        do_cmd(wiper_cmd_pkg::CMD_DEC_STEP, 2'h1);
        check(o_wiper.wiper1, 9'h0ff);
        do_cmd(4'hc, 2'h0);
        do_cmd(wiper_cmd_pkg::CMD_INC_STEP, 2'h3);
        check(o_wiper.wiper0, 9'h1fe);
    endtask

    task automatic t_shift();
        logic [8:0] e;
        wr(2'h0, 9'h000);
        e = 9'h000;
        for (int i = 0; i < 11; i++) begin
            do_cmd(wiper_cmd_pkg::CMD_INC_6DB, 2'h0);
            e = (e == 9'h000) ? 9'h001 : (e >= 9'h100) ? 9'h1ff : e << 1;
            check(o_wiper.wiper0, e);
        end
        for (int i = 0; i < 11; i++) begin
            do_cmd(wiper_cmd_pkg::CMD_DEC_6DB, 2'h0);
            e = e >> 1;
            check(o_wiper.wiper0, e);
        end
        wr(2'h0, 9'h000);
        wr(2'h1, 9'h101);
        wr(2'h2, 9'h040);
        do_cmd(wiper_cmd_pkg::CMD_INC_6DB_A, 2'h0);
        chk3(9'h001, 9'h1ff, 7'h7f);
        do_cmd(wiper_cmd_pkg::CMD_DEC_6DB_A, 2'h0);
        chk3(9'h000, 9'h0ff, 7'h3f);
    endtask

    task automatic t_store();
        int n;
        @(posedge i_core_clk);
        i_write_protect_n <= 1'b1;
        wr(2'h0, 9'h123);
        tick(3);
        bus_master_model_inst.issue(wiper_cmd_pkg::CMD_STORE, 2'h0);
        n = 0;
        repeat (STORE + 8) begin
            #1;
            if (o_busy === 1'b1) n++;
            @(posedge i_core_clk);
        end
        check(9'(n), 9'(STORE));
        wr(2'h0, 9'h000);
        do_cmd(wiper_cmd_pkg::CMD_RESET, 2'h0);
        chk3(9'h123, 9'h000, 7'h00);
        bus_master_model_inst.issue(wiper_cmd_pkg::CMD_STORE, 2'h1);
        bus_master_model_inst.issue(wiper_cmd_pkg::CMD_INC_STEP, 2'h0);
        bus_master_model_inst.poll();
        check({8'h0, o_busy}, 9'h000);
        check(o_wiper.wiper0, 9'h123);
    endtask

    task automatic t_protect_and_resets();
        @(posedge i_core_clk);
        i_write_protect_n <= 1'b0;
        wr(2'h0, 9'h0aa);
        tick(3);
        bus_master_model_inst.issue(wiper_cmd_pkg::CMD_STORE, 2'h0);
        bus_master_model_inst.poll();
        do_cmd(wiper_cmd_pkg::CMD_RESTORE, 2'h0);
        check(o_wiper.wiper0, 9'h123);
        check({8'h0, o_mem_read_state}, 9'h001);
        do_cmd(wiper_cmd_pkg::CMD_NOP, 2'h0);
        check({8'h0, o_mem_read_state}, 9'h000);
        wr(2'h0, 9'h011);
        @(posedge i_core_clk);
        i_hw_reset_n <= 1'b0;
        tick(6);
        @(posedge i_core_clk);
        i_hw_reset_n <= 1'b1;
        tick(6);
        check(o_wiper.wiper0, 9'h123);
        wr(2'h2, 9'h011);
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        tick(2);
        @(posedge i_core_clk);
        i_rst <= 1'b0;
        tick(4);
        chk3(9'h123, 9'h000, 7'h00);
    endtask

    initial begin
        i_rst = 1'b1;
        i_hw_reset_n = 1'b1;
        i_write_protect_n = 1'b0;
        pins = 4'h0;
        repeat (20) @(posedge i_core_clk);
        i_rst <= 1'b0;
        tick(4);
        chk3(9'h000, 9'h000, 7'h00);
        check({8'h0, o_busy}, 9'h000);
        t_addr_pins();
        t_steps();
        t_shift();
        t_store();
        t_protect_and_resets();
        tally_and_finish();
    end
endmodule
`default_nettype wire
